// ===== include/pfc_pkg.sv
/*
 Constants, types and register map of the parallel flash host controller.
 Assumes a 250 MHz aclk and a byte-wide asynchronous flash behind the pins.
*/
package pfc_pkg;
	// Timing, in printed units and derived cycles
	localparam int CLK_PS = 4000;
	localparam int T_ACC_NS = 70;
	localparam int T_WP_NS = 40;
	localparam int T_REC_NS = 30;
	localparam int T_RST_NS = 500;
	localparam int T_PROG_US = 10;
	localparam int SYNC_STAGES = 2;
	localparam int ACC_CYC = (T_ACC_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int WP_CYC = (T_WP_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int REC_CYC = (T_REC_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int RST_CYC = (T_RST_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int PROG_CYC = (T_PROG_US * 1000000) / CLK_PS;
	typedef logic [11:0] pfc_cnt_t;
	localparam pfc_cnt_t ACC_CNT = pfc_cnt_t'(ACC_CYC + SYNC_STAGES - 1);
	localparam pfc_cnt_t WP_CNT = pfc_cnt_t'(WP_CYC - 1);
	localparam pfc_cnt_t REC_CNT = pfc_cnt_t'(REC_CYC - 1);
	localparam pfc_cnt_t RST_CNT = pfc_cnt_t'(RST_CYC - 1);
	localparam pfc_cnt_t PROG_CNT = pfc_cnt_t'(PROG_CYC);
	localparam pfc_cnt_t CNT_ZERO = 12'h000;
	localparam pfc_cnt_t CNT_ONE = 12'h001;
	// Flash geometry
	localparam int TOP_ADDRESS_BIT = 20;
	localparam int SECTOR_LO_BIT = 12;
	localparam int BLOCK_LO_BIT = 16;
	typedef logic [TOP_ADDRESS_BIT:0] pfc_addr_t;
	typedef logic [7:0] pfc_byte_t;
	localparam int COMPLETION_POLARITY_BIT = 7;
	localparam int BUSY_TOGGLE_BIT = 6;
	// Protection prefix defaults, values arbitrary
	localparam pfc_addr_t PFX_ADDR0 = 21'h000001;
	localparam pfc_addr_t PFX_ADDR1 = 21'h000002;
	localparam pfc_addr_t PFX_ADDR2 = 21'h000003;
	localparam pfc_byte_t PFX_DATA0 = 8'h01;
	localparam pfc_byte_t PFX_DATA1 = 8'h02;
	localparam pfc_byte_t PFX_DATA2 = 8'h03;
	localparam logic [1:0] STEP_LAST_PFX = 2'h2;
	localparam logic [1:0] STEP_TARGET = 2'h3;
	// Register map
	localparam int AXI_AW = 8;
	localparam logic [5:0] IDX_CTRL = 6'h00;
	localparam logic [5:0] IDX_ADDR = 6'h01;
	localparam logic [5:0] IDX_WDATA = 6'h02;
	localparam logic [5:0] IDX_STATUS = 6'h03;
	localparam int CTRL_READ_BIT = 0;
	localparam int CTRL_PROG_BIT = 1;
	localparam int CTRL_RST_BIT = 2;
	localparam int CTRL_WP_BIT = 8;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_TIMEOUT_BIT = 2;
	localparam int ST_REFUSED_BIT = 3;
	localparam int ST_DATA_LO = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Sequencer states
	typedef enum logic [6:0] {
		S_IDLE = 7'b0000001,
		S_WSET = 7'b0000010,
		S_WLOW = 7'b0000100,
		S_WREC = 7'b0001000,
		S_RLOW = 7'b0010000,
		S_RREC = 7'b0100000,
		S_RST = 7'b1000000
	} pfc_state_e;
endpackage

// ===== rtl/pfc_sync.sv
/*
 Two-stage synchroniser for a bus of pin inputs.
 Assumes the inputs are asynchronous to aclk; bits are not coherent as a word.
*/
`timescale 1ns/100ps
module pfc_sync #(
	parameter int W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] q_reg;

	// First stage feeds only the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_reg <= '0;
			q_reg <= '0;
		end else if (clk_en) begin
			meta_reg <= d;
			q_reg <= meta_reg;
		end
	end
	assign q = q_reg;
endmodule

// ===== rtl/pfc_top.sv
/*
 Host controller for a byte-wide asynchronous flash: AXI4-Lite register slave,
 pin sequencer for reads, byte program with status polling, and reset pulse.
 Assumes the data pin wire is resolved outside from data_pins_out and data_pins_oe.
*/
`timescale 1ns/100ps
module pfc_top #(
	parameter pfc_pkg::pfc_addr_t PFX_A0 = pfc_pkg::PFX_ADDR0,
	parameter pfc_pkg::pfc_addr_t PFX_A1 = pfc_pkg::PFX_ADDR1,
	parameter pfc_pkg::pfc_addr_t PFX_A2 = pfc_pkg::PFX_ADDR2,
	parameter pfc_pkg::pfc_byte_t PFX_D0 = pfc_pkg::PFX_DATA0,
	parameter pfc_pkg::pfc_byte_t PFX_D1 = pfc_pkg::PFX_DATA1,
	parameter pfc_pkg::pfc_byte_t PFX_D2 = pfc_pkg::PFX_DATA2
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic [pfc_pkg::AXI_AW-1:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [pfc_pkg::AXI_AW-1:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	output pfc_pkg::pfc_addr_t flash_addr,
	input wire logic [7:0] data_pins_in,
	output logic [7:0] data_pins_out,
	output logic data_pins_oe,
	output logic chip_sel_n,
	output logic out_gate_n,
	output logic write_strobe_n,
	output logic write_protect_n,
	output logic flash_reset_n
);
	////////////////////////////////////////////////////////////////
	// Register bus
	logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
	logic [5:0] aw_idx_reg, aw_idx_next;
	logic aw_bad_reg, aw_bad_next;
	logic [31:0] wd_reg, wd_next;
	logic [3:0] ws_reg, ws_next;
	logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	pfc_pkg::pfc_addr_t tgt_addr_reg, tgt_addr_next;
	pfc_pkg::pfc_byte_t tgt_data_reg, tgt_data_next;
	logic wp_level_reg, wp_level_next;
	logic refused_reg, refused_next;
	logic go_read, go_prog, go_rst, clr_done, clr_timeout;
	logic busy;
	logic done_reg, done_next, timeout_reg, timeout_next;
	pfc_pkg::pfc_byte_t rd_byte_reg, rd_byte_next;

	// Channel handshakes, register writes and reads
	always_comb begin
		logic do_wr;
		logic [31:0] st;
		do_wr = aw_hold_reg && w_hold_reg && !bvalid_reg;
		st = 32'h0000_0000;
		aw_hold_next = aw_hold_reg;
		w_hold_next = w_hold_reg;
		aw_idx_next = aw_idx_reg;
		aw_bad_next = aw_bad_reg;
		wd_next = wd_reg;
		ws_next = ws_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		tgt_addr_next = tgt_addr_reg;
		tgt_data_next = tgt_data_reg;
		wp_level_next = wp_level_reg;
		go_read = 1'b0;
		go_prog = 1'b0;
		go_rst = 1'b0;
		clr_done = 1'b0;
		clr_timeout = 1'b0;
		refused_next = refused_reg;
		if (s_awvalid && !aw_hold_reg) begin
			aw_hold_next = 1'b1;
			aw_idx_next = s_awaddr[7:2];
			aw_bad_next = (s_awaddr[7:2] > pfc_pkg::IDX_STATUS);
		end
		if (s_wvalid && !w_hold_reg) begin
			w_hold_next = 1'b1;
			wd_next = s_wdata;
			ws_next = s_wstrb;
		end
		if (bvalid_reg && s_bready) begin
			bvalid_next = 1'b0;
		end
		if (do_wr) begin
			aw_hold_next = 1'b0;
			w_hold_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = aw_bad_reg ? pfc_pkg::RESP_SLVERR : pfc_pkg::RESP_OKAY;
			if (!aw_bad_reg && ws_reg[0]) begin
				case (aw_idx_reg)
				pfc_pkg::IDX_CTRL: begin
					// Starts while busy are refused, no commands mid-program
					if (busy && (wd_reg[2:0] != 3'h0)) begin
						refused_next = 1'b1;
					end else begin
						go_read = wd_reg[pfc_pkg::CTRL_READ_BIT];
						go_prog = wd_reg[pfc_pkg::CTRL_PROG_BIT];
						go_rst = wd_reg[pfc_pkg::CTRL_RST_BIT];
					end
				end
				pfc_pkg::IDX_STATUS: begin
					clr_done = wd_reg[pfc_pkg::ST_DONE_BIT];
					clr_timeout = wd_reg[pfc_pkg::ST_TIMEOUT_BIT];
					if (wd_reg[pfc_pkg::ST_REFUSED_BIT]) begin
						refused_next = 1'b0;
					end
				end
				default: begin
				end
				endcase
			end
			if (!aw_bad_reg && aw_idx_reg == pfc_pkg::IDX_CTRL && ws_reg[1]) begin
				wp_level_next = wd_reg[pfc_pkg::CTRL_WP_BIT];
			end
			if (!aw_bad_reg && !busy && aw_idx_reg == pfc_pkg::IDX_ADDR) begin
				tgt_addr_next = wd_reg[pfc_pkg::TOP_ADDRESS_BIT:0];
			end
			if (!aw_bad_reg && !busy && aw_idx_reg == pfc_pkg::IDX_WDATA && ws_reg[0]) begin
				tgt_data_next = wd_reg[7:0];
			end
		end
		st[pfc_pkg::ST_BUSY_BIT] = busy;
		st[pfc_pkg::ST_DONE_BIT] = done_reg;
		st[pfc_pkg::ST_TIMEOUT_BIT] = timeout_reg;
		st[pfc_pkg::ST_REFUSED_BIT] = refused_reg;
		st[pfc_pkg::ST_DATA_LO +: 8] = rd_byte_reg;
		if (rvalid_reg && s_rready) begin
			rvalid_next = 1'b0;
		end
		if (s_arvalid && !rvalid_reg) begin
			rvalid_next = 1'b1;
			rresp_next = pfc_pkg::RESP_OKAY;
			case (s_araddr[7:2])
			pfc_pkg::IDX_CTRL: rdata_next = 32'(wp_level_reg) << pfc_pkg::CTRL_WP_BIT;
			pfc_pkg::IDX_ADDR: rdata_next = 32'(tgt_addr_reg);
			pfc_pkg::IDX_WDATA: rdata_next = 32'(tgt_data_reg);
			pfc_pkg::IDX_STATUS: rdata_next = st;
			default: begin
				rdata_next = 32'h0000_0000;
				rresp_next = pfc_pkg::RESP_SLVERR;
			end
			endcase
		end
	end

	// Register bus state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			aw_idx_reg <= 6'h00;
			aw_bad_reg <= 1'b0;
			wd_reg <= 32'h0000_0000;
			ws_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= 2'h0;
			rvalid_reg <= 1'b0;
			rresp_reg <= 2'h0;
			rdata_reg <= 32'h0000_0000;
			tgt_addr_reg <= '0;
			tgt_data_reg <= 8'h00;
			wp_level_reg <= 1'b1;
			refused_reg <= 1'b0;
		end else if (clk_en) begin
			aw_hold_reg <= aw_hold_next;
			w_hold_reg <= w_hold_next;
			aw_idx_reg <= aw_idx_next;
			aw_bad_reg <= aw_bad_next;
			wd_reg <= wd_next;
			ws_reg <= ws_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			tgt_addr_reg <= tgt_addr_next;
			tgt_data_reg <= tgt_data_next;
			wp_level_reg <= wp_level_next;
			refused_reg <= refused_next;
		end
	end
	assign s_awready = !aw_hold_reg;
	assign s_wready = !w_hold_reg;
	assign s_bvalid = bvalid_reg;
	assign s_bresp = bresp_reg;
	assign s_arready = !rvalid_reg;
	assign s_rvalid = rvalid_reg;
	assign s_rdata = rdata_reg;
	assign s_rresp = rresp_reg;

	////////////////////////////////////////////////////////////////
	// Pin sequencer
	pfc_pkg::pfc_state_e state_reg, state_next;
	pfc_pkg::pfc_cnt_t cnt_reg, cnt_next, poll_reg, poll_next;
	logic [1:0] step_reg, step_next;
	logic prog_reg, prog_next, polling_reg, polling_next, seen_reg, seen_next;
	pfc_pkg::pfc_addr_t fa_reg, fa_next;
	pfc_pkg::pfc_byte_t fd_reg, fd_next;
	logic doe_reg, doe_next, cs_reg, cs_next, og_reg, og_next, ws_n_reg, ws_n_next;
	logic wp_reg, wp_next, rst_reg, rst_next;
	logic [7:0] din_sync;

	pfc_sync #(.W(8)) u_din_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.clk_en(clk_en),
		.d(data_pins_in),
		.q(din_sync)
	);
	assign busy = (state_reg != pfc_pkg::S_IDLE);

	// Next state of the pin sequence
	always_comb begin
		logic cnt_end;
		logic good;
		cnt_end = (cnt_reg == pfc_pkg::CNT_ZERO);
		good = 1'b0;
		state_next = state_reg;
		cnt_next = cnt_end ? cnt_reg : cnt_reg - pfc_pkg::CNT_ONE;
		step_next = step_reg;
		prog_next = prog_reg;
		polling_next = polling_reg;
		seen_next = seen_reg;
		poll_next = polling_reg ? poll_reg + pfc_pkg::CNT_ONE : poll_reg;
		fa_next = fa_reg;
		fd_next = fd_reg;
		doe_next = doe_reg;
		cs_next = cs_reg;
		og_next = og_reg;
		ws_n_next = ws_n_reg;
		wp_next = wp_reg;
		rst_next = rst_reg;
		rd_byte_next = rd_byte_reg;
		done_next = done_reg && !clr_done;
		timeout_next = timeout_reg && !clr_timeout;
		case (state_reg)
		pfc_pkg::S_IDLE: begin
			wp_next = wp_level_reg; // Level only moves between sequences
			if (go_rst) begin
				rst_next = 1'b0; // Reset pulse returns flash to read mode
				cnt_next = pfc_pkg::RST_CNT;
				state_next = pfc_pkg::S_RST;
			end else if (go_prog) begin
				// One byte per start, prefix writes first
				prog_next = 1'b1;
				step_next = 2'h0;
				fa_next = PFX_A0;
				fd_next = PFX_D0;
				doe_next = 1'b1;
				cs_next = 1'b0;
				cnt_next = pfc_pkg::REC_CNT;
				state_next = pfc_pkg::S_WSET;
			end else if (go_read) begin
				// Read with select and gate low, pins released
				prog_next = 1'b0;
				fa_next = tgt_addr_reg;
				cs_next = 1'b0;
				og_next = 1'b0;
				cnt_next = pfc_pkg::ACC_CNT;
				state_next = pfc_pkg::S_RLOW;
			end
		end
		pfc_pkg::S_WSET: begin
			if (cnt_end) begin
				ws_n_next = 1'b0; // Strobe falls after select, gate high
				cnt_next = pfc_pkg::WP_CNT;
				state_next = pfc_pkg::S_WLOW;
			end
		end
		pfc_pkg::S_WLOW: begin
			if (cnt_end) begin
				ws_n_next = 1'b1; // Long low pulse, data latched on rise
				cs_next = 1'b1;
				cnt_next = pfc_pkg::REC_CNT;
				state_next = pfc_pkg::S_WREC;
			end
		end
		pfc_pkg::S_WREC: begin
			if (cnt_end) begin
				doe_next = 1'b0; // Pins released before any read
				if (step_reg != pfc_pkg::STEP_TARGET) begin
					step_next = step_reg + 2'h1;
					doe_next = 1'b1;
					cs_next = 1'b0;
					cnt_next = pfc_pkg::REC_CNT;
					state_next = pfc_pkg::S_WSET;
					case (step_reg)
					2'h0: begin
						fa_next = PFX_A1;
						fd_next = PFX_D1;
					end
					2'h1: begin
						fa_next = PFX_A2;
						fd_next = PFX_D2;
					end
					default: begin
						fa_next = tgt_addr_reg;
						fd_next = tgt_data_reg;
					end
					endcase
				end else begin
					// Fourth write done, poll the target address
					polling_next = 1'b1;
					seen_next = 1'b0;
					poll_next = pfc_pkg::CNT_ZERO;
					cs_next = 1'b0;
					og_next = 1'b0;
					cnt_next = pfc_pkg::ACC_CNT;
					state_next = pfc_pkg::S_RLOW;
				end
			end
		end
		pfc_pkg::S_RLOW: begin
			if (cnt_end) begin
				rd_byte_next = din_sync;
				cs_next = 1'b1;
				og_next = 1'b1;
				cnt_next = pfc_pkg::REC_CNT;
				state_next = pfc_pkg::S_RREC;
			end
		end
		pfc_pkg::S_RREC: begin
			// Done when polarity bit true and toggle bit stopped
			good = (rd_byte_reg[pfc_pkg::COMPLETION_POLARITY_BIT]
				== tgt_data_reg[pfc_pkg::COMPLETION_POLARITY_BIT]) && seen_reg
				&& (rd_byte_reg[pfc_pkg::BUSY_TOGGLE_BIT] == fd_reg[pfc_pkg::BUSY_TOGGLE_BIT]);
			if (cnt_end) begin
				seen_next = 1'b1;
				fd_next = rd_byte_reg;
				if (!prog_reg || good) begin
					polling_next = 1'b0;
					done_next = 1'b1;
					state_next = pfc_pkg::S_IDLE;
				end else if (poll_reg >= pfc_pkg::PROG_CNT) begin
					polling_next = 1'b0; // Past the bounded program time
					timeout_next = 1'b1;
					state_next = pfc_pkg::S_IDLE;
				end else begin
					cs_next = 1'b0;
					og_next = 1'b0;
					cnt_next = pfc_pkg::ACC_CNT;
					state_next = pfc_pkg::S_RLOW;
				end
			end
		end
		pfc_pkg::S_RST: begin
			if (cnt_end) begin
				rst_next = 1'b1;
				done_next = 1'b1;
				state_next = pfc_pkg::S_IDLE;
			end
		end
		default: begin
			state_next = pfc_pkg::S_IDLE;
		end
		endcase
	end

	// Sequencer and pin registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= pfc_pkg::S_IDLE;
			cnt_reg <= pfc_pkg::CNT_ZERO;
			poll_reg <= pfc_pkg::CNT_ZERO;
			step_reg <= 2'h0;
			prog_reg <= 1'b0;
			polling_reg <= 1'b0;
			seen_reg <= 1'b0;
			fa_reg <= '0;
			fd_reg <= 8'h00;
			doe_reg <= 1'b0;
			cs_reg <= 1'b1;
			og_reg <= 1'b1;
			ws_n_reg <= 1'b1;
			wp_reg <= 1'b1;
			rst_reg <= 1'b1;
			rd_byte_reg <= 8'h00;
			done_reg <= 1'b0;
			timeout_reg <= 1'b0;
		end else if (clk_en) begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			poll_reg <= poll_next;
			step_reg <= step_next;
			prog_reg <= prog_next;
			polling_reg <= polling_next;
			seen_reg <= seen_next;
			fa_reg <= fa_next;
			fd_reg <= fd_next;
			doe_reg <= doe_next;
			cs_reg <= cs_next;
			og_reg <= og_next;
			ws_n_reg <= ws_n_next;
			wp_reg <= wp_next;
			rst_reg <= rst_next;
			rd_byte_reg <= rd_byte_next;
			done_reg <= done_next;
			timeout_reg <= timeout_next;
		end
	end
	assign flash_addr = fa_reg;
	assign data_pins_out = fd_reg;
	assign data_pins_oe = doe_reg;
	assign chip_sel_n = cs_reg;
	assign out_gate_n = og_reg;
	assign write_strobe_n = ws_n_reg;
	assign write_protect_n = wp_reg;
	assign flash_reset_n = rst_reg;

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	strobe_needs_sel_a: assert property (!ws_n_reg |-> !cs_reg)
		else $error("write strobe low without chip select");
	pins_float_a: assert property (doe_reg |-> og_reg)
		else $error("host drives data while output gate low");
	gate_strobe_a: assert property (!og_reg |-> ws_n_reg && !doe_reg)
		else $error("output gate low during write");
	wp_steady_a: assert property (busy && $past(busy) |-> $stable(wp_reg))
		else $error("write protect moved inside a sequence");
	strobe_width_a: assert property ($fell(ws_n_reg) && clk_en |-> !ws_n_reg[*8])
		else $error("write strobe pulse too short");
	prefix_addr_a: assert property (!ws_n_reg && step_reg == 2'h0 |-> fa_reg == PFX_A0)
		else $error("first prefix write at wrong address");
	target_write_a: assert property (!ws_n_reg && step_reg == pfc_pkg::STEP_TARGET
		|-> fa_reg == tgt_addr_reg && fd_reg == tgt_data_reg)
		else $error("fourth write does not carry target");
	poll_bound_a: assert property (polling_reg |-> poll_reg <= pfc_pkg::PROG_CNT
		+ pfc_pkg::ACC_CNT + pfc_pkg::REC_CNT + 12'h004)
		else $error("polling ran past program bound");
	reset_pulse_a: assert property ($fell(rst_reg) && clk_en |-> !rst_reg[*8])
		else $error("flash reset pulse too short");

	prog_done_c: cover property (prog_reg && state_reg == pfc_pkg::S_RREC ##1 done_reg);
	read_done_c: cover property (go_read ##[1:40] done_reg);
	timeout_c: cover property ($rose(timeout_reg));
	refused_c: cover property ($rose(refused_reg));
endmodule

// ===== verif/pfc_fm.sv
/*
 Behavioural byte-wide flash facing the host controller.
 Assumes the bench resolves the shared data wire.
*/
`timescale 1ns/100ps
module pfc_fm #(
	parameter int PROG_NS = 3000,
	parameter logic BOOT_TOP = 1'b1
) (
	input wire logic [20:0] addr,
	input wire logic [7:0] din,
	output logic [7:0] dout,
	output logic doe,
	input wire logic cs_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic wp_n,
	input wire logic rst_n
);
	logic [7:0] mem [int];
	logic [20:0] la, ta;
	logic [7:0] td = 8'h00;
	logic [1:0] step = 2'h0;
	logic busy = 1'b0, tog = 1'b0, lowp = 1'b0, arm = 1'b0;
	realtime tf = 0;
	event go;
	wire wact = !cs_n && !we_n;
	wire ract = !cs_n && !oe_n;
	function automatic logic [7:0] arr(input logic [20:0] a);
		return mem.exists(a) ? mem[a] : 8'hff;
	endfunction
	task automatic wr(input logic [7:0] d);
		if (busy) return;
		if ($realtime - tf < 5.0 || !oe_n || !rst_n) return;
		case (step)
		2'h0: step = (la == pfc_pkg::PFX_ADDR0 && d == pfc_pkg::PFX_DATA0) ? 2'h1 : 2'h0;
		2'h1: step = (la == pfc_pkg::PFX_ADDR1 && d == pfc_pkg::PFX_DATA1) ? 2'h2 : 2'h0;
		2'h2: step = (la == pfc_pkg::PFX_ADDR2 && d == pfc_pkg::PFX_DATA2) ? 2'h3 : 2'h0;
		default: begin
			step = 2'h0;
			if (wp_n || la[20:16] != {5{BOOT_TOP}}) begin
				ta = la;
				td = d;
				busy = 1'b1;
				-> go;
			end
		end
		endcase
	endtask
	////////////////////////////////////////
	// Address at the later falling edge of strobe and select
	always @(posedge wact) begin
		la = addr;
		tf = $realtime;
	end
	// Data at the earlier rising edge ends the write
	always @(negedge wact) wr(din);
	// Self-timed program completion
	always @(go) begin
		#(PROG_NS);
		if (busy) mem[ta] = arr(ta) & td;
		busy = 1'b0;
	end
	// Reset pin drops sequence and program
	always @(negedge rst_n) begin
		step = 2'h0;
		busy = 1'b0;
	end
	// Read drive, status while programming
	always @* begin
		doe = ract && rst_n;
		dout = busy ? {~td[7], tog, td[5:0]} : arr(addr);
	end
	// End of a read: toggle flips while busy, idle power once armed
	always @(negedge ract) begin
		tog = busy ? ~tog : tog;
		lowp = arm;
	end
	// Bus movement arms idling and wakes the device
	always @(addr or posedge cs_n) arm = 1'b1;
	always @(addr or posedge ract) lowp = 1'b0;
endmodule

// ===== verif/tb_top.sv
/*
 Self-checking bench for the flash host controller.
 Assumes the flash model and the controller package.
*/
`timescale 1ns/100ps
module tb_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
	logic [31:0] s_wdata = 32'h0, s_rdata;
	logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0;
	logic s_rready = 1'b0, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [1:0] s_bresp, s_rresp;
	pfc_pkg::pfc_addr_t flash_addr;
	logic [7:0] data_pins_in, data_pins_out, fdout;
	logic data_pins_oe, fdoe, chip_sel_n, out_gate_n, write_strobe_n;
	logic write_protect_n, flash_reset_n;
	int n_fail = 0;
	int n_compared = 0;
	int rlow = 0;
	logic clk_en = 1'b1;
	pfc_top pfc_top_inst (.aclk, .aresetn, .clk_en, .s_awaddr, .s_awvalid, .s_awready,
		.s_wdata, .s_wstrb(4'hf), .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
		.s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
		.flash_addr, .data_pins_in, .data_pins_out, .data_pins_oe, .chip_sel_n,
		.out_gate_n, .write_strobe_n, .write_protect_n, .flash_reset_n);
	pfc_fm pfc_fm_inst (.addr(flash_addr), .din(data_pins_in), .dout(fdout), .doe(fdoe),
		.cs_n(chip_sel_n), .oe_n(out_gate_n), .we_n(write_strobe_n),
		.wp_n(write_protect_n), .rst_n(flash_reset_n));
	// Wire level; a released wire changes every half cycle
	always_comb data_pins_in = data_pins_oe ? data_pins_out : fdoe ? fdout : {4{aclk, ~aclk}};
	always #2 aclk = ~aclk;
	always @(posedge aclk) if (flash_reset_n === 1'b0) rlow <= rlow + 1;
	////////////////////////////////////////
	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s exp %h got %h", s, e, g);
		end
	endtask
	// Register write, both channels offered together
	task automatic axw(logic [7:0] a, logic [31:0] d, logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
			n++;
		end while (s_bvalid !== 1'b1 && n < 100);
		s_bready <= 1'b0;
		chk("bvalid", 32'h1, {31'h0, s_bvalid});
		chk("bresp", {30'h0, er}, {30'h0, s_bresp});
	endtask
	// Register read and response code check
	task automatic axr(logic [7:0] a, logic [1:0] er, output logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_arready) s_arvalid <= 1'b0;
			n++;
		end while (s_rvalid !== 1'b1 && n < 100);
		d = s_rdata;
		s_rready <= 1'b0;
		chk("rvalid", 32'h1, {31'h0, s_rvalid});
		chk("rresp", {30'h0, er}, {30'h0, s_rresp});
	endtask
	task automatic rchk(string s, logic [7:0] a, logic [31:0] e, logic [1:0] er);
		logic [31:0] d;
		axr(a, er, d);
		chk(s, e, d);
	endtask
	// Poll status until the sequencer is idle
	task automatic wait_idle;
		logic [31:0] st;
		int n;
		n = 0;
		do begin
			axr(8'h0c, 2'h0, st);
			n++;
		end while (st[0] !== 1'b0 && n < 2000);
		chk("idle", 32'h0, {31'h0, st[0]});
	endtask
	////////////////////////////////////////
	task automatic t_basic;
		rchk("ctrl", 8'h00, 32'h100, 2'h0);
		rchk("status", 8'h0c, 32'h0, 2'h0);
		chk("pins", 32'h3e, {26'h0, chip_sel_n, out_gate_n, write_strobe_n,
			flash_reset_n, write_protect_n, data_pins_oe});
		axw(8'h40, 32'h1, 2'h2);
		rchk("unmapped", 8'h40, 32'h0, 2'h2);
		$display("test basic done");
	endtask
	task automatic t_read;
		pfc_fm_inst.mem[21'h12345] = 8'ha5;
		axw(8'h04, 32'h12345, 2'h0);
		axw(8'h00, 32'h101, 2'h0);
		clk_en <= 1'b0;
		repeat (40) @(posedge aclk);
		chk("frozen select", 32'h0, {31'h0, chip_sel_n});
		clk_en <= 1'b1;
		wait_idle;
		rchk("read byte", 8'h0c, 32'ha502, 2'h0);
		axw(8'h0c, 32'he, 2'h0);
		rchk("cleared", 8'h0c, 32'ha500, 2'h0);
		$display("test read done");
	endtask
	task automatic t_prog;
		axw(8'h04, 32'h2345, 2'h0);
		axw(8'h08, 32'h3c, 2'h0);
		axw(8'h00, 32'h102, 2'h0);
		axw(8'h00, 32'h102, 2'h0);
		axw(8'h08, 32'h55, 2'h0);
		wait_idle;
		rchk("prog status", 8'h0c, 32'h3c0a, 2'h0);
		chk("array", 32'h3c, {24'h0, pfc_fm_inst.arr(21'h2345)});
		rchk("wdata kept", 8'h08, 32'h3c, 2'h0);
		axw(8'h0c, 32'he, 2'h0);
		$display("test program done");
	endtask
	task automatic t_wp;
		axw(8'h00, 32'h0, 2'h0);
		axw(8'h04, 32'h1f0010, 2'h0);
		axw(8'h08, 32'h0, 2'h0);
		axw(8'h00, 32'h2, 2'h0);
		chk("wp pin", 32'h0, {31'h0, write_protect_n});
		wait_idle;
		rchk("wp status", 8'h0c, 32'hff04, 2'h0);
		chk("boot byte", 32'hff, {24'h0, pfc_fm_inst.arr(21'h1f0010)});
		axw(8'h0c, 32'he, 2'h0);
		axw(8'h00, 32'h100, 2'h0);
		$display("test protect done");
	endtask
	task automatic t_frst;
		rlow = 0;
		axw(8'h00, 32'h104, 2'h0);
		wait_idle;
		chk("reset width", 32'd125, rlow);
		axw(8'h04, 32'h12345, 2'h0);
		axw(8'h00, 32'h101, 2'h0);
		wait_idle;
		rchk("after reset", 8'h0c, 32'ha502, 2'h0);
		$display("test flash reset done");
	endtask
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		t_basic;
		t_read;
		t_prog;
		t_wp;
		t_frst;
		final_report;
	end
	// Watchdog, several times the expected run
	initial begin
		#200us;
		n_fail++;
		final_report;
	end
endmodule
